// [core/ccrb_pkg.sv]
// package: constants and types of the codec control register bank
package ccrb_pkg;

  // ----------------------------------------------------------------
  // secondary word layout
  // ----------------------------------------------------------------
  localparam int unsigned WORD_BITS   = 16;    // bits per serial word
  localparam int unsigned HDR_BITS    = 8;     // bits 15..8 arrive first
  localparam int unsigned SYNC_STAGES = 2;     // pin synchroniser depth

  // ----------------------------------------------------------------
  // register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] ADDR_NOP       = 5'h00;  // no operation
  localparam logic [4:0] ADDR_MODE_MON  = 5'h01;  // mode_and_monitor_control
  localparam logic [4:0] ADDR_GAIN_OVF  = 5'h02;  // gain_and_overflow_control
  localparam logic [7:0] MODE_MON_RST   = 8'h00;  // value after reset
  localparam logic [7:0] GAIN_OVF_RST   = 8'h00;  // value after reset

  // ----------------------------------------------------------------
  // field positions inside the header byte (word bits 15..8)
  // ----------------------------------------------------------------
  localparam int unsigned HDR_RW_BIT   = 5;  // word bit 13, one means read
  localparam int unsigned HDR_ADDR_MSB = 4;  // word bit 12

  // ----------------------------------------------------------------
  // field positions inside the control registers
  // ----------------------------------------------------------------
  localparam int unsigned M_SWRST   = 7;  // software reset
  localparam int unsigned M_PWDN    = 6;  // software power down
  localparam int unsigned M_DLOOP   = 5;  // digital loopback
  localparam int unsigned M_ALOOP   = 4;  // analog loopback
  localparam int unsigned M_MONSRC  = 3;  // monitor source select
  localparam int unsigned M_MONG_LO = 0;  // monitor gain, three bits
  localparam int unsigned G_LINE_LO = 5;  // line input gain, three bits
  localparam int unsigned G_DAC_LO  = 2;  // dac output gain, three bits
  localparam int unsigned G_SPK     = 1;  // speaker driver on
  localparam int unsigned G_OVF     = 0;  // adc overflow status

  // ----------------------------------------------------------------
  // gain encodings
  // ----------------------------------------------------------------
  localparam logic [2:0] MON_MUTE  = 3'h0;  // monitor muted
  localparam logic [2:0] MON_0DB   = 3'h1;
  localparam logic [2:0] MON_3DB   = 3'h2;
  localparam logic [2:0] MON_6DB   = 3'h3;
  localparam logic [2:0] MON_9DB   = 3'h4;
  localparam logic [2:0] MON_12DB  = 3'h5;
  localparam logic [2:0] AMP_0DB   = 3'h0;  // line: 0 dB, dac: 0 dB
  localparam logic [2:0] AMP_STEP1 = 3'h1;  // line: +6 dB, dac: -6 dB
  localparam logic [2:0] AMP_STEP2 = 3'h2;  // line: +12 dB, dac: -12 dB
  localparam logic [2:0] AMP_STEP3 = 3'h3;  // line: +18 dB, dac: -18 dB
  localparam logic [2:0] AMP_MUTE  = 3'h4;  // either amplifier muted

  // ----------------------------------------------------------------
  // frame state machine, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,  // waiting for frame sync
    ST_SHIFT  = 3'b010,  // sixteen bits in flight
    ST_TAIL   = 3'b100   // word done, waiting for frame sync to rise
  } ccrb_state_t;

  // ----------------------------------------------------------------
  // settings handed to the analog and datapath logic
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       power_down;    // software power down
    logic       digital_loop;  // digital loopback on
    logic       analog_loop;   // analog loopback on
    logic       mon_src_line;  // monitor fed by line input amp, else dac
    logic [2:0] mon_gain;      // monitor amp gain code
    logic [2:0] line_gain;     // line_receive_input amp gain code
    logic [2:0] dac_gain;      // dac output amp gain code
    logic       spk_on;        // speaker driver 0 dB, else muted
  } ccrb_ctrl_t;

endpackage

// [core/ccrb_pin_sync.sv]
// two-stage pin synchroniser with edge detection
`timescale 1ns/1ps
`default_nettype none

module ccrb_pin_sync #(
  parameter int unsigned WIDTH = 3   // number of pins
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  input  wire logic [WIDTH-1:0] i_pin,
  output logic      [WIDTH-1:0] o_level,
  output logic      [WIDTH-1:0] o_rise,
  output logic      [WIDTH-1:0] o_fall
);

  // ----------------------------------------------------------------
  // synchroniser and history
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] meta_ff;  // first stage, read only by sync_ff
  logic [WIDTH-1:0] sync_ff;  // second stage, safe to use
  logic [WIDTH-1:0] prev_ff;  // previous safe level for edges

  // meta stage is never looked at by any gate, only by the next flop
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_ff <= '0;
      sync_ff <= '0;
      prev_ff <= '0;
    end else begin
      meta_ff <= i_pin;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end

  // edges found per pin
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_edge
      assign o_rise[g] = sync_ff[g] & ~prev_ff[g];
      assign o_fall[g] = ~sync_ff[g] & prev_ff[g];
    end
  endgenerate

  assign o_level = sync_ff;

endmodule
`default_nettype wire

// [core/ccrb_top.sv]
// codec control register bank reached through secondary serial frames
`timescale 1ns/1ps
`default_nettype none

module ccrb_top (
  input  wire logic                i_ref_clk,       // 125 MHz core clock
  input  wire logic                i_rst,           // async, active high
  input  wire logic                i_sclk,          // serial clock pin
  input  wire logic                i_fs_n,          // frame sync pin, low in frame
  input  wire logic                i_din,           // serial data in pin
  input  wire logic                i_sec_frame,     // current frame is secondary
  input  wire logic                i_adc_overflow,  // adc overflow event pulse
  output logic                     o_dout,          // serial data out
  output logic                     o_dout_oe_n,     // low while dout is driven
  output logic                     o_soft_reset,    // one-cycle software reset
  output ccrb_pkg::ccrb_ctrl_t     o_ctrl           // current settings
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pin_lvl;   // {din, fs_n, sclk} after two flops
  logic [2:0] pin_rise;  // rising edges
  logic [2:0] pin_fall;  // falling edges

  ccrb_pin_sync #(
    .WIDTH (3)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_pin     ({i_din, i_fs_n, i_sclk}),
    .o_level   (pin_lvl),
    .o_rise    (pin_rise),
    .o_fall    (pin_fall)
  );

  logic din_s;      // synchronised data in
  logic fs_n_s;     // synchronised frame sync
  logic sclk_rise;  // serial clock rose
  logic sclk_fall;  // serial clock fell
  assign din_s     = pin_lvl[2];
  assign fs_n_s    = pin_lvl[1];
  assign sclk_rise = pin_rise[0];
  assign sclk_fall = pin_fall[0];

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  ccrb_pkg::ccrb_state_t state_ff, nxt_state;  // frame sequencer
  logic [15:0] rx_ff,   nxt_rx;                // word shifted in from din
  logic [4:0]  rxc_ff,  nxt_rxc;               // falling edges seen
  logic [3:0]  txc_ff,  nxt_txc;               // rising edges seen
  logic [7:0]  rd_ff,   nxt_rd;                // read byte being sent
  logic        dout_ff, nxt_dout;              // data out flop
  logic        oe_n_ff, nxt_oe_n;              // output enable flop
  logic        sec_ff,  nxt_sec;               // frame marked secondary
  logic [7:0]  mode_ff, nxt_mode;              // mode_and_monitor_control
  logic [7:1]  gain_ff, nxt_gain;              // writable part of gain reg
  logic        ovf_ff,  nxt_ovf;               // sticky adc overflow flag
  logic        srst_ff, nxt_srst;              // software reset pulse
  logic        armed_ff, nxt_armed;            // frame sync seen idle since reset

  // register read mux, selected by the header address
  function automatic logic [7:0] reg_read(input logic [4:0] addr,
                                          input logic [7:0] mode,
                                          input logic [7:1] gain,
                                          input logic       ovf);
    logic [7:0] val;
    val = 8'h00;
    unique case (addr)
      ccrb_pkg::ADDR_MODE_MON: val = mode;
      ccrb_pkg::ADDR_GAIN_OVF: val = {gain, ovf};
      default:                 val = 8'h00;         // nop and holes read zero
    endcase
    return val;
  endfunction

  // header decode helpers
  logic [15:0] rx_shift;  // word after the current din bit
  logic        hdr_ok;    // header bits 15 and 14 zero, valid at 8th fall
  logic        hdr_rd;    // read requested, valid at 8th fall
  logic [4:0]  hdr_addr;  // addressed register, valid at 8th fall
  logic        word_ok;   // word bits 15 and 14 zero, valid at 16th fall
  assign rx_shift = {rx_ff[14:0], din_s};
  // at the 8th fall the header byte still sits in the low byte of the shifter
  assign hdr_ok   = (rx_shift[7:6] == 2'b00);
  assign hdr_rd   = rx_shift[ccrb_pkg::HDR_RW_BIT];
  assign hdr_addr = rx_shift[ccrb_pkg::HDR_ADDR_MSB -: 5];
  assign word_ok  = (rx_shift[15:14] == 2'b00);

  // ----------------------------------------------------------------
  // next-state logic: frame, shifting, registers
  // ----------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    nxt_rx    = rx_ff;
    nxt_rxc   = rxc_ff;
    nxt_txc   = txc_ff;
    nxt_rd    = rd_ff;
    nxt_dout  = dout_ff;
    nxt_oe_n  = oe_n_ff;
    nxt_sec   = sec_ff;
    nxt_mode  = mode_ff;
    nxt_gain  = gain_ff;
    nxt_ovf   = ovf_ff;
    nxt_srst  = 1'b0;
    // the synchroniser resets low, which reads as frame sync asserted;
    // no frame may open until the pin has been seen idle once
    nxt_armed = armed_ff | fs_n_s;

    unique case (state_ff)
      // frame starts when synced frame sync goes low
      ccrb_pkg::ST_IDLE: begin
        if (!fs_n_s && armed_ff) begin
          nxt_state = ccrb_pkg::ST_SHIFT;
          nxt_rx    = 16'h0000;
          nxt_rxc   = 5'h00;
          nxt_txc   = 4'h0;
          nxt_rd    = 8'h00;
          nxt_dout  = 1'b0;       // upper byte of answer is zero
          nxt_oe_n  = 1'b0;
          nxt_sec   = i_sec_frame;
        end
      end
      // collect sixteen bits on falling edges, send on rising edges
      ccrb_pkg::ST_SHIFT: begin
        if (fs_n_s) begin
          // short frame: abandoned, no write commits; a completed read header of the status has already cleared it
          nxt_state = ccrb_pkg::ST_IDLE;
          nxt_oe_n  = 1'b1;
        end else begin
          if (sclk_rise) begin
            nxt_txc = txc_ff + 4'h1;
            // rising edge 8 onward shifts the read byte; edges 9 to 16 present bits 7..0
            if (txc_ff >= 4'h7) begin
              nxt_dout = rd_ff[7];
              nxt_rd   = {rd_ff[6:0], 1'b0};
            end
          end
          if (sclk_fall) begin
            nxt_rx  = rx_shift;
            nxt_rxc = rxc_ff + 5'h01;
            // header complete: fetch read data in time for bit 7
            if (rxc_ff == 5'(ccrb_pkg::HDR_BITS - 1)) begin
              if (sec_ff && hdr_ok && hdr_rd) begin
                nxt_rd = reg_read(hdr_addr, mode_ff, gain_ff, ovf_ff);
                // reading the status clears it; a new event below wins
                if (hdr_addr == ccrb_pkg::ADDR_GAIN_OVF) begin
                  nxt_ovf = 1'b0;
                end
              end
            end
            // last bit: commit a write
            if (rxc_ff == 5'(ccrb_pkg::WORD_BITS - 1)) begin
              nxt_state = ccrb_pkg::ST_TAIL;
              if (sec_ff && word_ok && !rx_shift[13]) begin
                unique case (rx_shift[12:8])
                  ccrb_pkg::ADDR_MODE_MON: begin
                    if (rx_shift[ccrb_pkg::M_SWRST]) begin
                      // software reset clears every writable bit
                      nxt_mode = ccrb_pkg::MODE_MON_RST;
                      nxt_gain = ccrb_pkg::GAIN_OVF_RST[7:1];
                      nxt_srst = 1'b1;
                    end else begin
                      nxt_mode = rx_shift[7:0];
                    end
                  end
                  ccrb_pkg::ADDR_GAIN_OVF: begin
                    // status bit 0 is not writable
                    nxt_gain = rx_shift[7:1];
                  end
                  default: begin
                    // nop and unlisted addresses store nothing
                    nxt_mode = mode_ff;
                  end
                endcase
              end
            end
          end
        end
      end
      // hold the line until frame sync rises, then release dout
      ccrb_pkg::ST_TAIL: begin
        if (fs_n_s) begin
          nxt_state = ccrb_pkg::ST_IDLE;
          nxt_oe_n  = 1'b1;
          nxt_dout  = 1'b0;
        end
      end
      default: begin
        nxt_state = ccrb_pkg::ST_IDLE;
        nxt_oe_n  = 1'b1;
      end
    endcase

    // overflow event set wins over a clearing read in the same cycle
    if (i_adc_overflow) begin
      nxt_ovf = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= ccrb_pkg::ST_IDLE;
      rx_ff    <= 16'h0000;
      rxc_ff   <= 5'h00;
      txc_ff   <= 4'h0;
      rd_ff    <= 8'h00;
      dout_ff  <= 1'b0;
      oe_n_ff  <= 1'b1;
      sec_ff   <= 1'b0;
      mode_ff  <= ccrb_pkg::MODE_MON_RST;
      gain_ff  <= ccrb_pkg::GAIN_OVF_RST[7:1];
      ovf_ff   <= 1'b0;
      srst_ff  <= 1'b0;
      armed_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      rx_ff    <= nxt_rx;
      rxc_ff   <= nxt_rxc;
      txc_ff   <= nxt_txc;
      rd_ff    <= nxt_rd;
      dout_ff  <= nxt_dout;
      oe_n_ff  <= nxt_oe_n;
      sec_ff   <= nxt_sec;
      mode_ff  <= nxt_mode;
      gain_ff  <= nxt_gain;
      ovf_ff   <= nxt_ovf;
      srst_ff  <= nxt_srst;
      armed_ff <= nxt_armed;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all straight from flops
  // ----------------------------------------------------------------
  assign o_dout       = dout_ff;
  assign o_dout_oe_n  = oe_n_ff;
  assign o_soft_reset = srst_ff;

  assign o_ctrl.power_down   = mode_ff[ccrb_pkg::M_PWDN];
  assign o_ctrl.digital_loop = mode_ff[ccrb_pkg::M_DLOOP];
  assign o_ctrl.analog_loop  = mode_ff[ccrb_pkg::M_ALOOP];
  assign o_ctrl.mon_src_line = mode_ff[ccrb_pkg::M_MONSRC];
  assign o_ctrl.mon_gain     = mode_ff[ccrb_pkg::M_MONG_LO +: 3];
  assign o_ctrl.line_gain    = gain_ff[ccrb_pkg::G_LINE_LO +: 3];
  assign o_ctrl.dac_gain     = gain_ff[ccrb_pkg::G_DAC_LO +: 3];
  assign o_ctrl.spk_on       = gain_ff[ccrb_pkg::G_SPK];

endmodule
`default_nettype wire

// [tb/ccrb_properties.sv]
// concurrent checks on the register bank's ports
`timescale 1ns/1ps
`default_nettype none

module ccrb_properties (
  input wire logic                 i_ref_clk,       // core clock
  input wire logic                 i_rst,           // async reset, active high
  input wire logic                 i_sclk,          // link clock pin
  input wire logic                 i_fs_n,          // frame sync pin
  input wire logic                 i_din,           // serial data in
  input wire logic                 i_sec_frame,     // secondary frame flag
  input wire logic                 i_adc_overflow,  // overflow event
  input wire logic                 o_dout,          // serial data out
  input wire logic                 o_dout_oe_n,     // low while dout driven
  input wire logic                 o_soft_reset,    // software reset pulse
  input wire ccrb_pkg::ccrb_ctrl_t o_ctrl           // current settings
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // ----------------------------------------------------------------
  // frame sequences
  // ----------------------------------------------------------------
  // device starts driving the serial output
  sequence frame_open_s;
    $fell(o_dout_oe_n);
  endsequence
  // header slots carry no data, so dout stays low well into them
  sequence header_quiet_s;
    (!o_dout)[*8] ##1 (!o_dout)[*8] ##1 (!o_dout)[*8];
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  reset_state_a:
    assert property ($fell(i_rst) |-> (o_ctrl == '0) && o_dout_oe_n && !o_soft_reset)
    else $error("outputs not idle after hardware reset");
  sw_reset_pulse_a:
    assert property (o_soft_reset |=> !o_soft_reset)
    else $error("software reset pulse longer than one cycle");
  sw_reset_clear_a:
    assert property (o_soft_reset |=> (o_ctrl == '0)[*2])
    else $error("settings not cleared by software reset");
  sw_reset_frame_a:
    assert property (o_soft_reset |-> !i_fs_n)
    else $error("software reset outside a frame");
  ctrl_frame_only_a:
    assert property ($changed(o_ctrl) |-> !i_fs_n)
    else $error("settings changed outside a frame");
  oe_open_a:
    assert property (frame_open_s |-> !$past(i_fs_n, 2))
    else $error("dout enabled without frame sync");
  oe_release_a:
    assert property ($rose(i_fs_n) |-> ##[1:5] o_dout_oe_n)
    else $error("dout not released after frame");
  header_zero_a:
    assert property (frame_open_s |-> header_quiet_s)
    else $error("dout high in header slots");
  primary_quiet_a:
    assert property ((!i_sec_frame && !o_dout_oe_n) |-> !o_dout)
    else $error("dout high in a primary frame");
endmodule
`default_nettype wire

// [tb/ccrb_host_model.sv]
// host serial port model that issues secondary frames
`timescale 1ns/1ps
`default_nettype none

module ccrb_host_model (
  input  wire logic i_ref_clk,    // bench clock, pacing only
  input  wire logic i_dout,       // device serial data out
  input  wire logic i_dout_oe_n,  // low while device drives dout
  output logic      o_sclk,       // link clock, still between frames
  output logic      o_fs_n,       // frame sync, low in frame
  output logic      o_din         // serial data to device
);
  initial begin
    o_sclk = 1'b0;
    o_fs_n = 1'b1;
    o_din  = 1'b0;
  end

  // half of an 80 ns link period, changes land on falling core edges
  task automatic half();
    repeat (5) @(negedge i_ref_clk);
  endtask

  // one word, msb first: header byte then data byte
  task automatic xfer(input logic [15:0] w, output logic [15:0] rd);
    rd     = 16'h0000;
    o_fs_n = 1'b0;
    half();
    for (int i = 15; i >= 0; i--) begin
      o_sclk = 1'b1;
      o_din  = w[i];
      half();
      o_sclk = 1'b0;  // device takes din on this fall
      half();
      // sampled late in the period, long after dout moved on the rise
      rd[i] = i_dout & ~i_dout_oe_n;
    end
    half();
    half();  // keep sync low until the word has acted
    o_fs_n = 1'b1;
    o_din  = ~o_din;  // released line never shows the last bit
    half();
  endtask

  // frame cut short after the header byte: the device must drop it
  task automatic cut(input logic [15:0] w);
    o_fs_n = 1'b0;
    half();
    for (int i = 15; i >= 8; i--) begin
      o_sclk = 1'b1;
      o_din  = w[i];
      half();
      o_sclk = 1'b0;
      half();
    end
    o_fs_n = 1'b1;  // clock stays still from here on
    half();
    half();
  endtask
endmodule
`default_nettype wire

// [tb/ccrb_tb_top.sv]
// self-checking bench for the codec control register bank
`timescale 1ns/1ps
`default_nettype none

module ccrb_tb_top;
  logic                 ref_clk = 1'b0;            // 125 MHz core clock
  logic                 rst, sec, ovf;             // reset, frame kind, overflow event
  logic                 sclk, fs_n, din, dout, oe_n, swr;  // link and pulse
  ccrb_pkg::ccrb_ctrl_t ctrl;                      // settings seen
  logic [7:0]           mode_e;                    // expected mode register
  logic [7:1]           gain_e;                    // expected gain bits
  logic                 ovf_e;                     // expected overflow status
  logic [31:0]          seed, r;                   // random state
  int                   fails, n_tests, sr_seen, sr_exp;

  always #4 ref_clk = ~ref_clk;

  ccrb_top i_dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_sclk(sclk), .i_fs_n(fs_n),
    .i_din(din), .i_sec_frame(sec), .i_adc_overflow(ovf), .o_dout(dout),
    .o_dout_oe_n(oe_n), .o_soft_reset(swr), .o_ctrl(ctrl));
  ccrb_host_model i_host (.i_ref_clk(ref_clk), .i_dout(dout), .i_dout_oe_n(oe_n),
    .o_sclk(sclk), .o_fs_n(fs_n), .o_din(din));

  // count software reset pulses mid-cycle, away from the edge that launches them
  always @(negedge ref_clk) begin
    if (swr === 1'b1)
      sr_seen++;
  end

  // xorshift source, fixed start
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // settings expected from the two register images
  function automatic ccrb_pkg::ccrb_ctrl_t ctrl_exp(input logic [7:0] m, input logic [7:1] g);
    return {m[6:3], m[2:0], g[7:5], g[4:2], g[1]};
  endfunction

  // read data expected for an address
  function automatic logic [7:0] rd_exp(input logic [4:0] a);
    case (a)
      ccrb_pkg::ADDR_MODE_MON: return mode_e;
      ccrb_pkg::ADDR_GAIN_OVF: return {gain_e, ovf_e};
      default:                 return 8'h00;
    endcase
  endfunction

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one frame, then the model update and all comparisons
  task automatic op(input logic [15:0] w, input logic s);
    logic [15:0] rd;
    logic [15:0] rexp;
    logic        ok;
    ok   = s && (w[15:14] == 2'b00);
    rexp = (ok && w[13]) ? {8'h00, rd_exp(w[12:8])} : 16'h0000;
    @(negedge ref_clk);
    sec = s;
    i_host.xfer(w, rd);
    if (ok && w[13] && w[12:8] == ccrb_pkg::ADDR_GAIN_OVF)
      ovf_e = 1'b0;
    if (ok && !w[13] && w[12:8] == ccrb_pkg::ADDR_MODE_MON) begin
      if (w[7]) begin
        mode_e = 8'h00;
        gain_e = 7'h00;
        sr_exp++;
      end else begin
        mode_e = w[7:0];
      end
    end
    if (ok && !w[13] && w[12:8] == ccrb_pkg::ADDR_GAIN_OVF)
      gain_e = w[7:1];
    repeat (4) @(negedge ref_clk);
    chk("read data", rd, rexp);
    chk("settings", {2'b00, ctrl}, {2'b00, ctrl_exp(mode_e, gain_e)});
    chk("soft resets", sr_seen[15:0], sr_exp[15:0]);
  endtask

  task automatic pulse_ovf();
    @(negedge ref_clk);
    ovf = 1'b1;
    @(negedge ref_clk);
    ovf   = 1'b0;
    ovf_e = 1'b1;
  endtask

  // hardware reset held for ten cycles, model cleared with it
  task automatic hw_reset();
    @(negedge ref_clk);
    rst = 1'b1;
    repeat (10) @(negedge ref_clk);
    rst    = 1'b0;
    mode_e = 8'h00;
    gain_e = 7'h00;
    ovf_e  = 1'b0;
    repeat (3) @(negedge ref_clk);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // test sequence
  // ----------------------------------------------------------------
  initial begin
    {rst, sec, ovf, fails, n_tests, sr_seen, sr_exp} = {3'b110, 128'h0};
    seed = 32'h0000001A;
    hw_reset();
    op(16'h2100, 1'b1);
    op(16'h2200, 1'b1);
    $display("test reset values done");
    // every monitor, line and dac gain code, read back each time
    for (int k = 0; k < 6; k++) begin
      r = rnd();
      op({8'h01, 1'b0, r[3:0], k[2:0]}, 1'b1);
      op({8'h02, k[2:0], 3'h4 - k[2:0], r[5:4]}, 1'b1);
      op(16'h2100, 1'b1);
      op(16'h2200, 1'b1);
    end
    $display("test gain codes done");
    // sticky overflow: kept through a gain write, survives soft reset, cleared by read
    pulse_ovf();
    op(16'h0201, 1'b1);
    op(16'h01FF, 1'b1);
    op(16'h2200, 1'b1);
    op(16'h2200, 1'b1);
    $display("test overflow done");
    // random mix of refused headers, primary frames, nop and unknown places
    for (int n = 0; n < 80; n++) begin
      r = rnd();
      if (r[20:18] == 3'h0)
        pulse_ovf();
      op({(r[23:22] == 2'h0) ? r[15:14] : 2'h0, r[13],
          (r[10:9] == 2'h3) ? r[12:8] : {3'h0, r[9:8]}, r[7:0]}, r[25:24] != 2'h0);
    end
    $display("test random frames done");
    // a soft reset word cut after its header must change nothing
    @(negedge ref_clk);
    sec = 1'b1;
    i_host.cut(16'h01FF);
    op(16'h2100, 1'b1);
    op(16'h2200, 1'b1);
    $display("test cut frame done");
    op(16'h017F, 1'b1);
    hw_reset();
    op(16'h2100, 1'b1);
    $display("test mid-run reset done");
    report_and_stop();
  end

  // cut a hang short at 400 us, well over twice the expected run of about 170 us
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
endmodule

bind ccrb_top ccrb_properties i_chk (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_sclk(i_sclk), .i_fs_n(i_fs_n), .i_din(i_din), .i_sec_frame(i_sec_frame),
  .i_adc_overflow(i_adc_overflow), .o_dout(o_dout), .o_dout_oe_n(o_dout_oe_n),
  .o_soft_reset(o_soft_reset), .o_ctrl(o_ctrl));
`default_nettype wire
